// File: hdl/pmg_decode.sv
// Decoder: mode and clock selects to per-module gating levels
`timescale 1ns/1ps
`default_nettype none
module pmg_decode
  import pmg_pkg::*;
(
  input  wire pmg_mode_t mode,
  input  wire logic [9:0] sel,
  pmg_gate_if.dec        g
);
  logic       sub_mode;
  logic       low_mode;
  logic [1:0] sci_sel;
  logic [1:0] lcd_sel;
  logic [1:0] tmf_sel;
  logic [1:0] wdog_sel;

  // Field split
  assign sci_sel = sel[PMG_SEL_SCI_LSB +: 2];
  assign lcd_sel = sel[PMG_SEL_LCD_LSB +: 2];
  assign tmf_sel = sel[PMG_SEL_TMF_LSB +: 2];
  assign wdog_sel = sel[PMG_SEL_WDOG_LSB +: 2];

  // Subclock-only modes versus all low-power modes
  assign sub_mode = (mode == PMG_SUBACT) || (mode == PMG_SUBSLP);
  assign low_mode = sub_mode || (mode == PMG_WATCH) || (mode == PMG_STANDBY);

  // Gating decisions
  always_comb begin
    g.main_osc_run = !low_mode;
    g.cpu_run = (mode == PMG_ACT_HS) || (mode == PMG_ACT_MS)
                || (mode == PMG_SUBACT);
    g.ports_hiz = (mode == PMG_STANDBY);
    g.pwm_adc_run = !low_mode;
    g.sci_reset = (mode == PMG_WATCH) || (mode == PMG_STANDBY);
    g.sci_run = low_mode ? (sub_mode && sci_sel == PMG_SCI_SUB_DIV2)
                         : 1'b1;
    g.lcd_run = 1'b1;
    g.tma_run = 1'b1;
    g.tmf_run = 1'b1;
    if (sub_mode || mode == PMG_WATCH) begin
      g.lcd_run = (lcd_sel == PMG_LCD_SUB) || (lcd_sel == PMG_LCD_SUB_DIV2)
                  || (lcd_sel == PMG_LCD_SUB_DIV4);
      g.tma_run = sel[PMG_SEL_TBASE];
      g.tmf_run = (tmf_sel == PMG_TMF_SUB_DIV4);
    end else if (mode == PMG_STANDBY) begin
      g.lcd_run = 1'b0;
      g.tma_run = 1'b0;
      g.tmf_run = 1'b0;
    end
    // Watchdog: on-chip oscillator exists only on variant with it
    case (mode)
      PMG_SUBACT: g.wdog_run = (wdog_sel == PMG_WDOG_SUB_DIV32)
                    || (sel[PMG_SEL_OSCVAR]
                        && wdog_sel == PMG_WDOG_OSC);
      PMG_WATCH,
      PMG_SUBSLP: g.wdog_run = sel[PMG_SEL_OSCVAR]
                    && ((wdog_sel == PMG_WDOG_SUB_DIV32)
                    || (wdog_sel == PMG_WDOG_OSC));
      PMG_STANDBY: g.wdog_run = sel[PMG_SEL_OSCVAR]
                     && (wdog_sel == PMG_WDOG_OSC);
      default: g.wdog_run = 1'b1;
    endcase
    g.irq_block = (mode == PMG_WATCH) || (mode == PMG_STANDBY);
    g.aec_irq_block = g.irq_block;
  end
endmodule
`default_nettype wire

// File: hdl/pmg_if.sv
// Interface: gating decisions passed from the decoder to the top
`timescale 1ns/1ps
`default_nettype none
interface pmg_gate_if;
  logic main_osc_run;
  logic cpu_run;
  logic ports_hiz;
  logic sci_run;
  logic sci_reset;
  logic lcd_run;
  logic tma_run;
  logic tmf_run;
  logic wdog_run;
  logic pwm_adc_run;
  logic irq_block;
  logic aec_irq_block;
  modport dec (output main_osc_run, cpu_run, ports_hiz, sci_run, sci_reset,
               lcd_run, tma_run, tmf_run, wdog_run, pwm_adc_run, irq_block,
               aec_irq_block);
  modport top (input main_osc_run, cpu_run, ports_hiz, sci_run, sci_reset,
               lcd_run, tma_run, tmf_run, wdog_run, pwm_adc_run, irq_block,
               aec_irq_block);
endinterface
`default_nettype wire

// File: hdl/pmg_pkg.sv
// Package: modes, clock selects, register map of the mode gating block
package pmg_pkg;

  // Operating modes, Gray coded
  typedef enum logic [2:0] {
    PMG_ACT_HS   = 3'h0,
    PMG_ACT_MS   = 3'h1,
    PMG_SLP_HS   = 3'h3,
    PMG_SLP_MS   = 3'h2,
    PMG_SUBACT   = 3'h6,
    PMG_SUBSLP   = 3'h7,
    PMG_WATCH    = 3'h5,
    PMG_STANDBY  = 3'h4
  } pmg_mode_t;

  // Serial interface clock select
  localparam logic [1:0] PMG_SCI_SUB_DIV2   = 2'h3;
  // Display controller clock select
  localparam logic [1:0] PMG_LCD_SUB        = 2'h1;
  localparam logic [1:0] PMG_LCD_SUB_DIV2   = 2'h2;
  localparam logic [1:0] PMG_LCD_SUB_DIV4   = 2'h3;
  // Second timer clock select
  localparam logic [1:0] PMG_TMF_SUB_DIV4   = 2'h3;
  // Watchdog clock select
  localparam logic [1:0] PMG_WDOG_SUB_DIV32 = 2'h1;
  localparam logic [1:0] PMG_WDOG_OSC       = 2'h2;

  // Register byte offsets
  localparam logic [3:0] PMG_OFS_MODE       = 4'h0;
  localparam logic [3:0] PMG_OFS_SEL        = 4'h4;
  localparam logic [3:0] PMG_OFS_STAT       = 4'h8;
  localparam logic [3:0] PMG_OFS_EVCNT      = 4'hC;

  // Select register fields
  localparam int PMG_SEL_SCI_LSB  = 0;
  localparam int PMG_SEL_LCD_LSB  = 2;
  localparam int PMG_SEL_TMF_LSB  = 4;
  localparam int PMG_SEL_WDOG_LSB = 6;
  localparam int PMG_SEL_TBASE    = 8;
  localparam int PMG_SEL_OSCVAR   = 9;

  // Reset values
  localparam logic [2:0]  PMG_MODE_RST = 3'h0;
  localparam logic [9:0]  PMG_SEL_RST  = 10'h000;

  // AXI responses
  localparam logic [1:0] PMG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PMG_RESP_SLVERR = 2'h2;

endpackage

// File: hdl/pmg_top.sv
// Top: mode gating block with AXI4-Lite registers and irq gating
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - In standby the port registers keep their value and outputs float.
// - Serial runs only on subclock/2 in sub modes, reset in watch/standby.
// - In watch/sub modes display runs on subclock, /2, /4 only, else holds.
// - First timer runs in watch/sub modes only as time base, else holds.
// - Watch and standby ignore the second irq line and the event irq line.
// - Watch and standby: the event counter counts but raises no interrupt.
// - Second timer runs in watch/sub modes only on subclock/4, else holds.
// - Subactive watchdog runs on subclock/32 or the on-chip oscillator.
// - Watch, subsleep, standby watchdog runs only on the oscillator variant.
module pmg_top
  import pmg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port data from port registers
  input  wire logic [7:0]  port_data_in,
  output logic [7:0]       port_out,
  output logic [7:0]       port_oe,
  // Raw interrupt events (same clock)
  input  wire logic        ext_irq_line_zero,
  input  wire logic        ext_irq_line_one,
  input  wire logic        event_counter_irq_line,
  input  wire logic [7:0]  wakeup_pins,
  input  wire logic        aec_event,
  // Gating outputs
  output logic             main_osc_run,
  output logic             sub_osc_run,
  output logic             cpu_run,
  output logic             serial_interface_run,
  output logic             serial_interface_reset,
  output logic             lcd_run,
  output logic             tma_run,
  output logic             tmf_run,
  output logic             watchdog_timer_run,
  output logic             pwm_adc_run,
  output logic             low_voltage_detector_run,
  output logic             aec_irq
);
  pmg_gate_if g ();
  pmg_mode_t  mode;
  logic [9:0] sel;
  logic [3:0] irq_flag;
  logic [7:0] evcnt;
  logic [7:0] port_hold;
  logic       aw_got;
  logic       w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;

  pmg_decode pmg_decode_i (
    .mode (mode),
    .sel  (sel),
    .g    (g)
  );

  ////////////////////////////////////////////////////////////////////////
  // AXI write channel, address and data taken in either order
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign wr_go = aw_got && w_got;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PMG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == PMG_OFS_MODE || aw_addr == PMG_OFS_SEL
                        || aw_addr == PMG_OFS_STAT) ? PMG_RESP_OKAY
                                                    : PMG_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; only byte lane 0 and 1 hold bits
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode <= pmg_mode_t'(PMG_MODE_RST);
      sel  <= PMG_SEL_RST;
    end else if (wr_go) begin
      if (aw_addr == PMG_OFS_MODE && w_strb[0])
        mode <= pmg_mode_t'(w_data[2:0]);
      if (aw_addr == PMG_OFS_SEL) begin
        if (w_strb[0])
          sel[7:0] <= w_data[7:0];
        if (w_strb[1])
          sel[9:8] <= w_data[9:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request flags; a new request beats a software clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_flag <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_go && aw_addr == PMG_OFS_STAT && w_strb[0] && w_data[i])
          irq_flag[i] <= 1'b0;
      end
      if (ext_irq_line_zero || |wakeup_pins)
        irq_flag[0] <= 1'b1;
      if (ext_irq_line_one && !g.irq_block)
        irq_flag[1] <= 1'b1;
      if (event_counter_irq_line && !g.irq_block)
        irq_flag[2] <= 1'b1;
      if (aec_event && evcnt == 8'hFF && !g.aec_irq_block)
        irq_flag[3] <= 1'b1;
    end
  end

  // Event counter keeps counting in every mode
  always_ff @(posedge mclk) begin
    if (!reset_n)
      evcnt <= 8'h00;
    else if (aec_event)
      evcnt <= evcnt + 8'h01;
  end
  assign aec_irq = irq_flag[3];

  ////////////////////////////////////////////////////////////////////////
  // Port drive; data register kept frozen while outputs float
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      port_hold <= 8'h00;
      port_out  <= 8'h00;
      port_oe   <= 8'h00;
    end else begin
      if (!g.ports_hiz)
        port_hold <= port_data_in;
      port_out <= g.ports_hiz ? 8'h00 : port_data_in;
      port_oe  <= g.ports_hiz ? 8'h00 : 8'hFF;
    end
  end

  // Registered gating levels
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      main_osc_run <= 1'b1;
      sub_osc_run  <= 1'b1;
      cpu_run      <= 1'b1;
      serial_interface_run   <= 1'b1;
      serial_interface_reset <= 1'b0;
      lcd_run      <= 1'b1;
      tma_run      <= 1'b1;
      tmf_run      <= 1'b1;
      watchdog_timer_run <= 1'b1;
      pwm_adc_run  <= 1'b1;
      low_voltage_detector_run <= 1'b1;
    end else begin
      main_osc_run <= g.main_osc_run;
      sub_osc_run  <= 1'b1;
      cpu_run      <= g.cpu_run;
      serial_interface_run   <= g.sci_run && !g.sci_reset;
      serial_interface_reset <= g.sci_reset;
      lcd_run      <= g.lcd_run;
      tma_run      <= g.tma_run;
      tmf_run      <= g.tmf_run;
      watchdog_timer_run <= g.wdog_run;
      pwm_adc_run  <= g.pwm_adc_run;
      low_voltage_detector_run <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= PMG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= PMG_RESP_OKAY;
      case (s_axi_araddr)
        PMG_OFS_MODE:  s_axi_rdata <= {29'h0, mode};
        PMG_OFS_SEL:   s_axi_rdata <= {22'h0, sel};
        PMG_OFS_STAT:  s_axi_rdata <= {20'h0, port_hold, irq_flag};
        PMG_OFS_EVCNT: s_axi_rdata <= {24'h0, evcnt};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= PMG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: testbench/pmg_top_bench.sv
// Bench: mode gating block driven over its register bus
`timescale 1ns/1ps
`default_nettype none
module pmg_top_bench
  import pmg_pkg::*;
;
  logic        mclk = 1'b0, reset_n = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, aec_irq, main_osc_run, sub_osc_run, cpu_run;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [7:0]  port_data_in = 8'h00, wakeup_pins = 8'h00, port_out, port_oe;
  logic        serial_interface_run, serial_interface_reset, lcd_run, tma_run;
  logic        tmf_run, watchdog_timer_run, pwm_adc_run;
  logic        low_voltage_detector_run;
  logic [3:0]  ev = 4'h0;
  int          errors = 0, comparisons = 0, cyc = 0;
  // No select, all favourable, mixed with variant, mixed without variant
  logic [9:0]  sels [4] = '{10'h000, 10'h377, 10'h28E, 10'h048};
  wire ext_irq_line_zero = ev[0], ext_irq_line_one = ev[1];
  wire event_counter_irq_line = ev[2], aec_event = ev[3];
  wire [10:0]  g = {main_osc_run, sub_osc_run, cpu_run, serial_interface_run,
    serial_interface_reset, lcd_run, tma_run, tmf_run, watchdog_timer_run,
    pwm_adc_run, low_voltage_detector_run};

  pmg_top pmg_top_i (.*);

  // 100 ns clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  // Hang guard: the run needs about fifteen hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(logic [3:0] a, logic [31:0] v, logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic setm(pmg_mode_t m);
    wr(PMG_OFS_MODE, {29'h0, m}, PMG_RESP_OKAY);
  endtask
  // One-cycle event pulses with a quiet cycle between them
  task automatic evt(int n, logic [3:0] v);
    repeat (n) begin
      ev <= v;
      @(posedge mclk);
      ev <= 4'h0;
      @(posedge mclk);
    end
  endtask
  // Expected gating word, ordered as g
  function automatic logic [10:0] exp_g(pmg_mode_t m, logic [9:0] s);
    logic lo, sb, sa, v;
    lo = m inside {PMG_WATCH, PMG_SUBACT, PMG_SUBSLP, PMG_STANDBY};
    sb = lo && m != PMG_STANDBY;
    sa = m inside {PMG_SUBACT, PMG_SUBSLP};
    v = s[PMG_SEL_OSCVAR];
    return {!lo, 1'b1,
      m inside {PMG_ACT_HS, PMG_ACT_MS, PMG_SUBACT},
      !lo || (sa && s[1:0] == PMG_SCI_SUB_DIV2),
      m inside {PMG_WATCH, PMG_STANDBY},
      !lo || (sb && s[3:2] != 2'h0),
      !lo || (sb && s[PMG_SEL_TBASE]),
      !lo || (sb && s[5:4] == PMG_TMF_SUB_DIV4),
      !lo || (m == PMG_SUBACT && s[7:6] == PMG_WDOG_SUB_DIV32)
        || (v && lo && s[7:6] == PMG_WDOG_OSC)
        || (v && sb && s[7:6] == PMG_WDOG_SUB_DIV32),
      !lo, 1'b1};
  endfunction
  task automatic wrap_up();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    pmg_mode_t m;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(PMG_OFS_MODE);
    chk("mode", d, {29'h0, PMG_MODE_RST});
    rd(PMG_OFS_SEL);
    chk("sel", d, {22'h0, PMG_SEL_RST});
    wr(PMG_OFS_EVCNT, 32'h55, PMG_RESP_SLVERR);
    rd(PMG_OFS_EVCNT);
    chk("evcnt", d, 32'h0);
    chk("rresp", {30'h0, rr}, {30'h0, PMG_RESP_OKAY});
    // Unmapped read answers an error with zero data
    rd(4'h2);
    chk("rresp", {30'h0, rr}, {30'h0, PMG_RESP_SLVERR});
    chk("rdata", d, 32'h0);
    // Only lane 0 enabled: the upper select bits must stay clear
    s_axi_wstrb <= 4'h1;
    wr(PMG_OFS_SEL, 32'h3FF, PMG_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(PMG_OFS_SEL);
    chk("lane", d, 32'hFF);
    $display("Test reset done");
    // Every mode under each select pattern
    foreach (sels[j]) begin
      for (int i = 0; i < 8; i++) begin
        m = pmg_mode_t'(i);
        wr(PMG_OFS_SEL, {22'h0, sels[j]}, PMG_RESP_OKAY);
        setm(m);
        repeat (2) @(posedge mclk);
        chk("gates", {21'h0, g}, {21'h0, exp_g(m, sels[j])});
        chk("oe", {24'h0, port_oe},
          m == PMG_STANDBY ? 32'h0 : 32'hFF);
      end
    end
    $display("Test mode table done");
    // Port value held while outputs float
    setm(PMG_ACT_HS);
    port_data_in <= 8'hA5;
    setm(PMG_STANDBY);
    port_data_in <= 8'h3C;
    repeat (2) @(posedge mclk);
    chk("port_out", {24'h0, port_out}, 32'h0);
    rd(PMG_OFS_STAT);
    chk("held", d & 32'hFF0, 32'hA50);
    setm(PMG_ACT_HS);
    chk("port_out", {24'h0, port_out}, 32'h3C);
    $display("Test standby ports done");
    evt(1, 4'h6);
    rd(PMG_OFS_STAT);
    chk("flags", d & 32'hF, 32'h6);
    wr(PMG_OFS_STAT, 32'hF, PMG_RESP_OKAY);
    setm(PMG_WATCH);
    evt(1, 4'h7);
    rd(PMG_OFS_STAT);
    chk("flags", d & 32'hF, 32'h1);
    wr(PMG_OFS_STAT, 32'hF, PMG_RESP_OKAY);
    // Counter wraps in watch with no interrupt, then raises one in active
    evt(255, 4'h8);
    rd(PMG_OFS_EVCNT);
    chk("count", d, 32'hFF);
    evt(1, 4'h8);
    rd(PMG_OFS_EVCNT);
    chk("count", d, 32'h0);
    chk("aec_irq", {31'h0, aec_irq}, 32'h0);
    setm(PMG_ACT_HS);
    evt(256, 4'h8);
    chk("aec_irq", {31'h0, aec_irq}, 32'h1);
    wr(PMG_OFS_STAT, 32'h8, PMG_RESP_OKAY);
    chk("aec_irq", {31'h0, aec_irq}, 32'h0);
    // Wake-up pin still flags in standby while the blocked lines stay quiet
    setm(PMG_STANDBY);
    wakeup_pins <= 8'h10;
    ev <= 4'h6;
    @(posedge mclk);
    wakeup_pins <= 8'h00;
    ev <= 4'h0;
    @(posedge mclk);
    rd(PMG_OFS_STAT);
    chk("wake", d & 32'hF, 32'h1);
    $display("Test interrupts done");
    wrap_up();
  end
endmodule
`default_nettype wire

// File: testbench/pmg_top_props.sv
// Checker: gating relations seen at the ports of the mode gating block
`timescale 1ns/1ps
`default_nettype none
module pmg_top_props (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [7:0] port_data_in,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe,
  input wire logic       aec_event,
  input wire logic       main_osc_run,
  input wire logic       sub_osc_run,
  input wire logic       cpu_run,
  input wire logic       serial_interface_run,
  input wire logic       serial_interface_reset,
  input wire logic       tma_run,
  input wire logic       pwm_adc_run,
  input wire logic       low_voltage_detector_run,
  input wire logic       aec_irq
);
  logic up;
  // Ports leave their reset value one edge after release
  always_ff @(posedge mclk) begin
    up <= reset_n;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////
  AST_SUBCLK: assert property (sub_osc_run)
    else $error("subclock stopped");
  AST_VDET: assert property (low_voltage_detector_run)
    else $error("voltage detector stopped");
  AST_FLOAT: assert property (up && port_oe == 8'h00 |->
    port_out == 8'h00 && !main_osc_run && !cpu_run && serial_interface_reset)
    else $error("ports float outside standby");
  AST_PORT: assert property (port_oe == 8'hFF &&
    $past(port_oe) == 8'hFF |-> port_out == $past(port_data_in))
    else $error("port copy wrong");
  AST_SCIRST: assert property (serial_interface_reset |->
    !serial_interface_run && !main_osc_run) else $error("serial reset wrong");
  AST_PWM: assert property (pwm_adc_run == main_osc_run)
    else $error("pwm gating wrong");
  AST_SUBACT: assert property (cpu_run && !main_osc_run |->
    !serial_interface_reset && port_oe == 8'hFF)
    else $error("subactive wrong");
  AST_FULL: assert property (main_osc_run |-> serial_interface_run
    && tma_run) else $error("peripheral stopped in fast mode");
  // The flag may rise only from an event outside watch and standby; the
  // registered serial reset level shows the mode the flag logic just saw
  AST_AECIRQ: assert property ($rose(aec_irq) |-> $past(aec_event)
    && !serial_interface_reset) else $error("event irq without cause");
  cover property (port_oe == 8'h00);
  cover property (cpu_run && !main_osc_run);
  cover property ($rose(aec_irq));
endmodule
bind pmg_top pmg_top_props pmg_top_props_i (.*);
`default_nettype wire
